// file: logic/ppm_pkg.sv
package ppm_pkg;
  // register word offsets on apb (byte addresses)
  localparam logic [7:0] OFF_PORT0_OUT = 8'h00;
  localparam logic [7:0] OFF_PORT1_OUT = 8'h04;
  localparam logic [7:0] OFF_PORT2_OUT = 8'h08;
  localparam logic [7:0] OFF_PORT3_OUT = 8'h0c;
  localparam logic [7:0] OFF_PORT0_DIR = 8'h10;
  localparam logic [7:0] OFF_PORT1_DIR = 8'h14;
  localparam logic [7:0] OFF_PORT2_DIR = 8'h18;
  localparam logic [7:0] OFF_PORT3_DIR = 8'h1c;
  localparam logic [7:0] OFF_PORT2_ALT = 8'h20;
  localparam logic [7:0] OFF_PORT3_ALT = 8'h24;
  localparam logic [7:0] OFF_FETCH_WAIT = 8'h28;
  localparam logic [7:0] OFF_PIN_IN0 = 8'h2c;
  localparam logic [7:0] OFF_PIN_IN1 = 8'h30;
  localparam logic [7:0] OFF_PIN_IN2 = 8'h34;
  localparam logic [7:0] OFF_PIN_IN3 = 8'h38;
  localparam logic [7:0] OFF_STATUS = 8'h3c;
  // reset values and field positions
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_WAIT = 2'h0;
  localparam int STAT_FETCH_EXT = 0;
  localparam int STAT_OUT_EN = 1;
  localparam int STAT_BUSY = 2;
  localparam int P3_MODE_CMP4 = 1; // timer17 four-pin compare mode bit
  localparam int P3_MODE_CAP = 0; // timer17 capture mode bit
  // one automatic state per external fetch byte
  localparam logic [2:0] FETCH_AUTO_STATES = 3'h1;

  // external bus request from the core
  typedef struct packed {
    logic fetch; // external program fetch cycle
    logic data_acc; // external data memory access
    logic addr_phase; // low address phase of muxed bus
    logic wr; // core writes data on muxed bus
    logic [15:0] addr;
    logic [7:0] wdata;
  } ppm_bus_s;

  // timer pin requests
  typedef struct packed {
    logic [7:0] p2_level; // compare levels for port 2
    logic [3:0] p3_level; // timer17 compare levels for port 3 bits 0..3
    logic [1:0] t17_mode; // bit1 four-pin compare, bit0 capture
  } ppm_tmr_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_AUTO = 3'b010,
    ST_WAIT = 3'b100
  } ppm_fetch_e;
endpackage : ppm_pkg

// file: logic/ppm_port_bank.sv
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - every port bit has its own direction bit that software writes.
// - with external fetch selected port 0 becomes the muxed low address and data bus during fetch and data cycles, regardless of direction.
// - any reset source returns all bits of ports 0 to 3 to floating inputs.
// - driven bits of ports 0, 1 and 2 float while the output enable pin is high.
// - with external fetch selected port 1 drives address bits 8 to 15 during external data accesses.
// - a port 2 bit with its alternate function set ignores its direction bit.
// - alternate port 2 pins output the compare level from the matching compare register.
// - port 3 bit 0 drives the timer17 compare level, or is a capture input in capture mode.
// - port 3 bits 1 to 3 drive compare levels only in four-pin compare mode.
// - port 3 bits 4 to 7 are capture inputs feeding the sample registers.
// - of port 3, only bits 0 to 3 obey the output enable pin.
// - a port 3 bit with its alternate function set ignores its direction bit.
// - external fetches stretch by one automatic state plus zero to three programmed waits.
module ppm_port_bank (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic hardware_reset_n, // reset pin, active low
  input wire logic break_instruction, // break reset pulse
  input wire logic watchdog_timer, // watchdog overflow pulse
  input wire logic opcode_trap, // illegal opcode trap pulse
  input wire logic external_fetch_select_n, // pin, low selects external fetch
  input wire logic out_enable_n, // output enable pin, active low
  input wire ppm_pkg::ppm_bus_s bus_req, // core external bus request
  input wire ppm_pkg::ppm_tmr_s tmr_req, // timer compare levels and mode
  output logic fetch_stall, // core stalls fetch while high
  output logic [7:0] muxed_low_addr_data, // port 0 read data in data phase
  output logic [4:0] edge_sample_input, // synced capture pins p3_0, p3_4..7
  input wire logic [7:0] pin0_i, // port 0 pad input
  input wire logic [7:0] pin1_i, // port 1 pad input
  input wire logic [7:0] pin2_i, // port 2 pad input
  input wire logic [7:0] pin3_i, // port 3 pad input
  output logic [31:0] pin_o, // pad outputs, port n at byte n
  output logic [31:0] pin_oe // pad enables, high drives
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] out_latch [4];
  logic [7:0] dir [4];
  logic [7:0] port2_alt_select;
  logic [7:0] port3_alt_select;
  logic [1:0] fetch_wait_control;
  logic [31:0] sync1;
  logic [31:0] sync2;
  logic [2:0] ctl_s1;
  logic [2:0] ctl_s2;
  logic [1:0] cnt;
  ppm_pkg::ppm_fetch_e state;
  ppm_pkg::ppm_fetch_e next_state;
  logic [1:0] next_cnt;

  // reset sources merged; pulses come from logic on pclk
  wire any_reset = ~ctl_s2[2] | break_instruction | watchdog_timer | opcode_trap;
  wire ext_fetch = ~ctl_s2[0];
  wire oe_pin = ~ctl_s2[1];
  // unaligned or unmapped writes are dropped, never aliased onto a register
  wire apb_wr = psel & penable & pwrite & hit_known;
  wire apb_rd = psel & ~pwrite;
  wire hit_latch = paddr[7:4] == 4'h0;
  wire hit_dir = paddr[7:4] == 4'h1;
  wire hit_pin = paddr >= ppm_pkg::OFF_PIN_IN0 && paddr <= ppm_pkg::OFF_PIN_IN3;
  wire hit_known = paddr <= ppm_pkg::OFF_STATUS && paddr[1:0] == 2'h0;
  wire [1:0] idx = paddr[3:2];
  wire [1:0] pin_idx = 2'(idx - 2'h3);

  ////////////////////////////////////////////////////////////////////////
  // pin and control synchronisers, two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 32'h0;
      sync2 <= 32'h0;
      ctl_s1 <= 3'h7;
      ctl_s2 <= 3'h7;
    end else begin
      sync1 <= {pin3_i, pin2_i, pin1_i, pin0_i};
      sync2 <= sync1;
      ctl_s1 <= {hardware_reset_n, out_enable_n, external_fetch_select_n};
      ctl_s2 <= ctl_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers; any reset source clears direction and alt bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        out_latch[i] <= ppm_pkg::RST_BYTE;
        dir[i] <= ppm_pkg::RST_BYTE;
      end
      port2_alt_select <= ppm_pkg::RST_BYTE;
      port3_alt_select <= ppm_pkg::RST_BYTE;
      fetch_wait_control <= ppm_pkg::RST_WAIT;
    end else if (any_reset) begin
      for (int i = 0; i < 4; i++) begin
        out_latch[i] <= ppm_pkg::RST_BYTE;
        dir[i] <= ppm_pkg::RST_BYTE;
      end
      port2_alt_select <= ppm_pkg::RST_BYTE;
      port3_alt_select <= ppm_pkg::RST_BYTE;
      fetch_wait_control <= ppm_pkg::RST_WAIT;
    end else if (apb_wr) begin
      if (hit_latch) out_latch[idx] <= pwdata[7:0];
      if (hit_dir) dir[idx] <= pwdata[7:0];
      if (paddr == ppm_pkg::OFF_PORT2_ALT) port2_alt_select <= pwdata[7:0];
      if (paddr == ppm_pkg::OFF_PORT3_ALT) port3_alt_select <= pwdata[7:0];
      if (paddr == ppm_pkg::OFF_FETCH_WAIT) fetch_wait_control <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pad steering per port
  wire p0_bus = ext_fetch & (bus_req.fetch | bus_req.data_acc);
  wire p0_drv_bus = p0_bus & (bus_req.addr_phase | bus_req.wr);
  wire [7:0] p0_bus_val = bus_req.addr_phase ? bus_req.addr[7:0] : bus_req.wdata;
  wire p1_bus = ext_fetch & bus_req.data_acc;
  wire t17_cmp = ~tmr_req.t17_mode[ppm_pkg::P3_MODE_CAP];
  wire t17_cmp4 = t17_cmp & tmr_req.t17_mode[ppm_pkg::P3_MODE_CMP4];
  // port 3 alternate drive: bit0 in compare mode, bits1..3 in four-pin mode, bits4..7 never
  wire [7:0] p3_alt_drv = {4'h0, {3{t17_cmp4}}, t17_cmp};
  wire [7:0] p3_alt_val = {4'h0, tmr_req.p3_level};
  // bus ownership of port 0 overrides direction
  wire [7:0] next_oe0 = p0_bus ? {8{p0_drv_bus & oe_pin}} : dir[0] & {8{oe_pin}};
  wire [7:0] next_o0 = p0_bus ? p0_bus_val : out_latch[0];
  wire [7:0] next_oe1 = (p1_bus ? 8'hff : dir[1]) & {8{oe_pin}};
  wire [7:0] next_o1 = p1_bus ? bus_req.addr[15:8] : out_latch[1];
  // port 2 alt bits take their level from the compare engine and drive regardless of direction
  wire [7:0] next_oe2 = ((port2_alt_select) | dir[2]) & {8{oe_pin}};
  wire [7:0] next_o2 = (port2_alt_select & tmr_req.p2_level) | (~port2_alt_select & out_latch[2]);
  wire [7:0] p3_drv = (port3_alt_select & p3_alt_drv) | (~port3_alt_select & dir[3]);
  // output enable gates only the low nibble of port 3
  wire [7:0] next_oe3 = p3_drv & {4'hf, {4{oe_pin}}};
  wire [7:0] next_o3 = (port3_alt_select & p3_alt_val) | (~port3_alt_select & out_latch[3]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o <= 32'h0;
      pin_oe <= 32'h0;
    end else if (any_reset) begin
      pin_o <= 32'h0;
      pin_oe <= 32'h0;
    end else begin
      pin_o <= {next_o3, next_o2, next_o1, next_o0};
      pin_oe <= {next_oe3, next_oe2, next_oe1, next_oe0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // external fetch stretch: one automatic state then programmed waits
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      ppm_pkg::ST_IDLE: begin
        if (ext_fetch && bus_req.fetch) next_state = ppm_pkg::ST_AUTO;
      end
      ppm_pkg::ST_AUTO: begin
        next_cnt = fetch_wait_control;
        next_state = (fetch_wait_control == 2'h0) ? ppm_pkg::ST_IDLE : ppm_pkg::ST_WAIT;
      end
      ppm_pkg::ST_WAIT: begin
        next_cnt = 2'(cnt - 2'h1);
        if (cnt == 2'h1) next_state = ppm_pkg::ST_IDLE;
      end
      default: begin
        next_state = ppm_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ppm_pkg::ST_IDLE;
      cnt <= 2'h0;
      fetch_stall <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      fetch_stall <= next_state != ppm_pkg::ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb read mux, zero wait states, error on unmapped address
  wire [31:0] status_word = {29'h0, state != ppm_pkg::ST_IDLE, oe_pin, ext_fetch};
  wire [7:0] rd_byte = hit_latch ? out_latch[idx] : hit_dir ? dir[idx] :
                       hit_pin ? sync2[pin_idx*8 +: 8] :
                       paddr == ppm_pkg::OFF_PORT2_ALT ? port2_alt_select :
                       paddr == ppm_pkg::OFF_PORT3_ALT ? port3_alt_select :
                       paddr == ppm_pkg::OFF_FETCH_WAIT ? {6'h0, fetch_wait_control} : 8'h00;
  // refused places read as zero so software never mistakes them for a register
  wire [31:0] next_rdata = !hit_known ? 32'h0 : paddr == ppm_pkg::OFF_STATUS ? status_word : {24'h0, rd_byte};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      muxed_low_addr_data <= 8'h00;
      edge_sample_input <= 5'h00;
    end else begin
      prdata <= (apb_rd && !penable) ? next_rdata : prdata;
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_known;
      muxed_low_addr_data <= sync2[7:0];
      // capture pins only when alt selected and not driving
      edge_sample_input <= {sync2[31:28] & port3_alt_select[7:4],
                            sync2[24] & port3_alt_select[0] & ~t17_cmp};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // reset sources
  a_reset_float: assert property (@(posedge pclk) disable iff (!presetn)
    any_reset |=> pin_oe == 32'h0) else $error("pins driven after reset source");
  a_reset_clears: assert property (@(posedge pclk) disable iff (!presetn)
    any_reset |=> {dir[0], dir[1], dir[2], dir[3]} == 32'h0 && {port2_alt_select, port3_alt_select} == 16'h0)
    else $error("settings kept after reset source");

  // output enable pin and external bus ownership
  a_oe_float_low: assert property (@(posedge pclk) disable iff (!presetn)
    !oe_pin |=> pin_oe[27:0] == 28'h0) else $error("port driven with oe high");
  a_p3_upper_oe: assert property (@(posedge pclk) disable iff (!presetn)
    !oe_pin && !any_reset && dir[3][7:4] != 4'h0 && port3_alt_select[7:4] == 4'h0 |=> pin_oe[31:28] != 4'h0)
    else $error("port3 upper nibble obeyed oe");
  a_p1_addr: assert property (@(posedge pclk) disable iff (!presetn)
    p1_bus && oe_pin && !any_reset |=> pin_o[15:8] == $past(bus_req.addr[15:8])) else $error("bad addr high");
  a_p1_drive: assert property (@(posedge pclk) disable iff (!presetn)
    p1_bus && oe_pin && !any_reset |=> pin_oe[15:8] == 8'hff) else $error("high address not driven");
  // port 0 belongs to the external bus while a cycle runs, and floats in the read data phase
  a_p0_bus_own: assert property (@(posedge pclk) disable iff (!presetn)
    p0_drv_bus && oe_pin && !any_reset |=> pin_oe[7:0] == 8'hff &&
    pin_o[7:0] == ($past(bus_req.addr_phase) ? $past(bus_req.addr[7:0]) : $past(bus_req.wdata)))
    else $error("port0 not carrying bus");
  a_p0_bus_float: assert property (@(posedge pclk) disable iff (!presetn)
    p0_bus && !p0_drv_bus |=> pin_oe[7:0] == 8'h00) else $error("port0 driven in read phase");

  // timer pins
  a_p2_alt: assert property (@(posedge pclk) disable iff (!presetn)
    !any_reset && oe_pin |=> (pin_oe[23:16] & $past(port2_alt_select)) == $past(port2_alt_select))
    else $error("alt port2 not driven");
  a_p2_level: assert property (@(posedge pclk) disable iff (!presetn)
    !any_reset |=> ((pin_o[23:16] ^ $past(tmr_req.p2_level)) & $past(port2_alt_select)) == 8'h00)
    else $error("port2 compare level lost");
  a_p3_bit0_cmp: assert property (@(posedge pclk) disable iff (!presetn)
    t17_cmp && port3_alt_select[0] && oe_pin && !any_reset |=>
    pin_oe[24] && pin_o[24] == $past(tmr_req.p3_level[0]))
    else $error("port3 bit0 compare not driven");
  a_p3_cap_in: assert property (@(posedge pclk) disable iff (!presetn)
    !t17_cmp && port3_alt_select[0] |=> !pin_oe[24]) else $error("capture pin driven");
  a_p3_upper: assert property (@(posedge pclk) disable iff (!presetn)
    !any_reset |=> pin_oe[31:28] == ($past(dir[3][7:4]) & ~$past(port3_alt_select[7:4])))
    else $error("port3 capture pin driven");
  a_p3_cmp4: assert property (@(posedge pclk) disable iff (!presetn)
    !t17_cmp4 && !any_reset |=> (pin_oe[27:25] & $past(port3_alt_select[3:1])) == 3'h0)
    else $error("p3 driven outside four-pin mode");
  a_p3_alt_dir: assert property (@(posedge pclk) disable iff (!presetn)
    !t17_cmp |=> (pin_oe[27:24] & $past(port3_alt_select[3:0])) == 4'h0)
    else $error("port3 alt bit follows direction");
  // plain bits follow the output latch
  a_gpio_out: assert property (@(posedge pclk) disable iff (!presetn)
    !any_reset && !p0_bus |=> pin_o[7:0] == $past(out_latch[0]) &&
    ((pin_o[23:16] ^ $past(out_latch[2])) & ~$past(port2_alt_select)) == 8'h00)
    else $error("plain bit lost its latch value");

  // fetch stretch
  a_fetch_start: assert property (@(posedge pclk) disable iff (!presetn)
    state == ppm_pkg::ST_IDLE && ext_fetch && bus_req.fetch |=> state == ppm_pkg::ST_AUTO && fetch_stall)
    else $error("fetch not stretched");
  a_fetch_nowait: assert property (@(posedge pclk) disable iff (!presetn)
    state == ppm_pkg::ST_AUTO && fetch_wait_control == 2'h0 |=> state == ppm_pkg::ST_IDLE)
    else $error("extra wait with none programmed");
  a_fetch_len: assert property (@(posedge pclk) disable iff (!presetn)
    state == ppm_pkg::ST_AUTO && fetch_wait_control == 2'h2 |=> state == ppm_pkg::ST_WAIT ##2 state == ppm_pkg::ST_IDLE)
    else $error("wrong fetch wait length");
  // longest stretch is the automatic state plus three waits; a longer run means a stuck machine
  logic [2:0] stall_run;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_run <= 3'h0;
    end else begin
      stall_run <= fetch_stall ? 3'(stall_run + 3'h1) : 3'h0;
    end
  end
  a_stall_bound: assert property (@(posedge pclk) disable iff (!presetn)
    stall_run <= 3'(ppm_pkg::FETCH_AUTO_STATES + 3'h3)) else $error("fetch stretched too long");

  // register bus
  a_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
    apb_wr && hit_dir && !any_reset |=> dir[$past(idx)] == $past(pwdata[7:0])) else $error("direction not stored");
  // zero wait bus: ready right after setup, error with it on a refused place
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready && pslverr == !$past(hit_known)) else $error("apb answer wrong");

  // main scenarios
  c_fetch_wait: cover property (@(posedge pclk) state == ppm_pkg::ST_WAIT);
  c_bus_port0: cover property (@(posedge pclk) p0_drv_bus && oe_pin);
  c_alt_p3: cover property (@(posedge pclk) t17_cmp4 && port3_alt_select[3:0] == 4'hf);
  c_capture_in: cover property (@(posedge pclk) edge_sample_input != 5'h00);
  c_reset_source: cover property (@(posedge pclk) any_reset && pin_oe != 32'h0);
endmodule : ppm_port_bank

// file: dv/ppm_pad_model.sv
`timescale 1ns/1ps
// board side of the pads: block drive wins, then the board, else the pad floats
module ppm_pad_model (
  input wire logic pclk, // bus clock
  input wire logic [31:0] pin_o, // block pad outputs
  input wire logic [31:0] pin_oe, // block pad enables
  input wire logic [31:0] board_val, // board drive value
  input wire logic [31:0] board_oe, // board drive enables
  output logic [31:0] pad // resolved pad level
);
  logic [31:0] float_pat = 32'h0f0f0f0f;

  // a floating pad flips every cycle so a stale level never passes for a drive
  always_ff @(posedge pclk) begin
    float_pat <= ~float_pat;
  end

  // resolve each pad from all drivers
  assign pad = (pin_oe & pin_o) | (~pin_oe & board_oe & board_val) | (~pin_oe & ~board_oe & float_pat);
endmodule : ppm_pad_model

// file: dv/ppm_port_bank_bench.sv
`timescale 1ns/1ps
module ppm_port_bank_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, pin_o, pin_oe, board_val, board_oe, pad, rd;
  logic hardware_reset_n, break_instruction, watchdog_timer, opcode_trap;
  logic external_fetch_select_n, out_enable_n, fetch_stall;
  logic [7:0] muxed_low_addr_data;
  logic [4:0] edge_sample_input;
  ppm_pkg::ppm_bus_s bus_req;
  ppm_pkg::ppm_tmr_s tmr_req;
  int n_mismatch = 0;
  int total_checks = 0;
  int n;

  ppm_port_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hardware_reset_n(hardware_reset_n), .break_instruction(break_instruction),
    .watchdog_timer(watchdog_timer), .opcode_trap(opcode_trap), .external_fetch_select_n(external_fetch_select_n),
    .out_enable_n(out_enable_n), .bus_req(bus_req), .tmr_req(tmr_req), .fetch_stall(fetch_stall),
    .muxed_low_addr_data(muxed_low_addr_data), .edge_sample_input(edge_sample_input), .pin0_i(pad[7:0]),
    .pin1_i(pad[15:8]), .pin2_i(pad[23:16]), .pin3_i(pad[31:24]), .pin_o(pin_o), .pin_oe(pin_oe));

  ppm_pad_model board (.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe), .board_val(board_val),
    .board_oe(board_oe), .pad(pad));

  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t no apb answer", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle(input int c);
    repeat (c) @(posedge pclk);
  endtask : settle

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // whole run is a few hundred cycles; this only cuts a hang
  initial begin
    #300000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    {presetn, psel, penable, pwrite, break_instruction, watchdog_timer, opcode_trap} = '0;
    {hardware_reset_n, external_fetch_select_n, out_enable_n} = 3'b111;
    {paddr, pwdata, board_val, board_oe} = '0;
    bus_req = '0;
    tmr_req = '0;
    settle(20);
    presetn <= 1'b1;
    check(pin_oe, 32'h0);
    for (int i = 0; i < 11; i++) begin
      apb(8'(i * 4), 1'b0, 32'h0);
      check(rd, 32'h0);
    end
    // plain i/o on port 1, board drives the input bits
    out_enable_n <= 1'b0;
    board_oe <= 32'h00005a00;
    board_val <= 32'h0000ff00;
    apb(ppm_pkg::OFF_PORT1_OUT, 1'b1, 32'h3c);
    apb(ppm_pkg::OFF_PORT1_DIR, 1'b1, 32'ha5);
    settle(4);
    check(32'(pin_oe[15:8]), 32'ha5);
    check(32'(pin_o[15:8] & 8'ha5), 32'h24);
    apb(ppm_pkg::OFF_PIN_IN1, 1'b0, 32'h0);
    check(rd, 32'h7e);
    // output enable pin floats ports 0..2 and port 3 bits 0..3 only
    board_oe <= 32'h0;
    apb(ppm_pkg::OFF_PORT0_DIR, 1'b1, 32'hff);
    apb(ppm_pkg::OFF_PORT2_DIR, 1'b1, 32'hff);
    apb(ppm_pkg::OFF_PORT3_DIR, 1'b1, 32'hff);
    settle(4);
    check(pin_oe, 32'hffffa5ff);
    out_enable_n <= 1'b1;
    settle(5);
    check(pin_oe, 32'hf0000000);
    out_enable_n <= 1'b0;
    // port 2 compare outputs override direction
    apb(ppm_pkg::OFF_PORT2_DIR, 1'b1, 32'h0);
    apb(ppm_pkg::OFF_PORT2_ALT, 1'b1, 32'h0f);
    tmr_req.p2_level <= 8'h05;
    settle(4);
    check(32'(pin_oe[23:16]), 32'h0f);
    check(32'(pin_o[19:16]), 32'h5);
    // timer17 four-pin compare, then capture
    apb(ppm_pkg::OFF_PORT3_DIR, 1'b1, 32'h0);
    apb(ppm_pkg::OFF_PORT3_ALT, 1'b1, 32'hff);
    tmr_req.p3_level <= 4'ha;
    tmr_req.t17_mode <= 2'b10;
    settle(4);
    check(32'(pin_oe[31:24]), 32'h0f);
    check(32'(pin_o[27:24]), 32'ha);
    tmr_req.t17_mode <= 2'b01;
    board_oe <= 32'hff000000;
    board_val <= 32'h91000000;
    settle(5);
    check(32'(pin_oe[31:24]), 32'h0);
    check(32'(edge_sample_input), 32'h13);
    board_val <= 32'h60000000;
    settle(5);
    check(32'(edge_sample_input), 32'h0c);
    // external bus: port 0 muxed, port 1 high address, direction ignored
    board_oe <= 32'h0;
    apb(ppm_pkg::OFF_PORT0_DIR, 1'b1, 32'h0);
    external_fetch_select_n <= 1'b0;
    bus_req <= '{fetch: 1'b0, data_acc: 1'b1, addr_phase: 1'b1, wr: 1'b0, addr: 16'h12ab, wdata: 8'h00};
    settle(5);
    check({pin_oe[15:0], pin_o[15:0]}, 32'hffff12ab);
    bus_req.addr_phase <= 1'b0;
    bus_req.wr <= 1'b1;
    bus_req.wdata <= 8'h6e;
    settle(4);
    check(32'({pin_oe[7:0], pin_o[7:0]}), 32'hff6e);
    // read data phase: port 0 floats and the board's byte comes back in
    bus_req.wr <= 1'b0;
    board_oe <= 32'h000000ff;
    board_val <= 32'h000000c3;
    settle(5);
    check(32'({pin_oe[7:0], muxed_low_addr_data}), 32'h00c3);
    board_oe <= 32'h0;
    bus_req <= '0;
    // fetch stretch for every wait setting
    for (int w = 0; w < 4; w++) begin
      apb(ppm_pkg::OFF_FETCH_WAIT, 1'b1, 32'(w));
      bus_req.fetch <= 1'b1;
      @(posedge pclk);
      bus_req.fetch <= 1'b0;
      n = 0;
      repeat (10) begin
        @(posedge pclk);
        if (fetch_stall === 1'b1) n++;
      end
      check(32'(n), 32'(w + 1));
    end
    // every reset source floats the pads and clears settings
    external_fetch_select_n <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      apb(ppm_pkg::OFF_PORT1_DIR, 1'b1, 32'hff);
      @(posedge pclk);
      hardware_reset_n <= (s != 0);
      break_instruction <= (s == 1);
      watchdog_timer <= (s == 2);
      opcode_trap <= (s == 3);
      @(posedge pclk);
      {break_instruction, watchdog_timer, opcode_trap} <= 3'b000;
      settle(3);
      hardware_reset_n <= 1'b1;
      settle(4);
      check(pin_oe, 32'h0);
      apb(ppm_pkg::OFF_PORT1_DIR, 1'b0, 32'h0);
      check(rd, 32'h0);
    end
    // unmapped place is refused
    apb(8'h40, 1'b0, 32'h0);
    check({rd[30:0], err}, 32'h1);
    tally_and_finish();
  end
endmodule : ppm_port_bank_bench
